/* File: verilog/sar_adc_map.vh */
// Register map, field positions and timing counts for the converter control
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH

`define ADDR_W 5
`define OFS_CONTROL 5'h00
`define OFS_RESULT_HIGH 5'h04
`define OFS_RESULT_LOW 5'h08
`define OFS_IRQ_STATUS 5'h0C
`define OFS_IRQ_MASK 5'h10

`define CTL_START 0
`define CTL_SPEED_LO 1
`define CTL_SPEED_HI 2
`define CTL_EOC 3
`define CTL_CHAN_LO 4
`define CTL_CHAN_HI 7

`define SPEED_DIV16 2'h0
`define SPEED_DIV8 2'h1
`define SPEED_DIV4 2'h2
`define SPEED_DIV1 2'h3

`define DIV16_LAST 4'hF
`define DIV8_LAST 4'h7
`define DIV4_LAST 4'h3
`define DIV1_LAST 4'h0

`define SETUP_LAST 4'h9
`define EDGES_LAST 2'h3
`define RESULT_BITS 10
`define SAR_MIDSCALE 10'h200
`define TOP_BIT 4'h9

`define CTL_RESET 8'h00
`define CHAN_RESET 4'h0
`define MASK_RESET 1'h0

`endif

/* File: verilog/conv_clock_div.v */
// Conversion clock tick generator: one-cycle pulse per conversion clock period
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_map.vh"

module conv_clock_div (
   input wire clk_i,
   input wire rst_i,
   input wire run_i,
   input wire [1:0] speed_i,
   output reg tick_o
);

reg [3:0] count;
wire [3:0] last;

function [3:0] div_last;
   input [1:0] speed;
   begin
      case (speed)
         `SPEED_DIV16: div_last = `DIV16_LAST;
         `SPEED_DIV8: div_last = `DIV8_LAST;
         `SPEED_DIV4: div_last = `DIV4_LAST;
         default: div_last = `DIV1_LAST;
      endcase
   end
endfunction

assign last = div_last(speed_i);

// RULE3 period of four
always @(posedge clk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      count <= 4'h0;
      tick_o <= 1'b0;
   end
   else if (!run_i)
   begin
      count <= 4'h0;
      tick_o <= 1'b0;
   end
   else if (count >= last)
   begin
      count <= 4'h0;
      tick_o <= 1'b1;
   end
   else
   begin
      count <= count + 4'h1;
      tick_o <= 1'b0;
   end
end

endmodule // conv_clock_div
`default_nettype wire

/* File: verilog/sar_adc_ctrl.v */
// Successive-approximation converter control with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_map.vh"

// What this block does and what software does around it
// RULE1 - Each result bit takes four conversion clock edges, ten bits in turn.
// RULE2 - Ten conversion clocks of set-up run before the first bit decision.
// RULE3 - Speed field value binary 10 gives a conversion clock of four oscillator periods.
// RULE4 - End-of-conversion flag becomes one when the sequence completes.
// RULE5 - Upper eight bits go to result high, lower two to result low.
// RULE6 - After loading results the block idles until software starts again.
// RULE7 - Software picks one of nine input channels before starting.
// RULE8 - Software sets the chosen analog pins to input mode beforehand.
// RULE9 - Software starts by writing one to control bit zero with channel and speed.
// RULE10 - Software polls control bit 3, zero while running, then reads result.
// RULE11 - At divide-by-sixteen, software waits three instruction slots before polling.
// RULE12 - Control bits 7 to 4 select the single connected input channel.
// RULE13 - Control bits 2 to 1 select the conversion clock speed.
// RULE14 - The approximation register starts at 200H and updates after each decision.
// RULE15 - A new conversion overwrites the stored result, read or not.
// RULE16 - Low result bits sit in bits 1:0, upper bits read zero.
module sar_adc_ctrl (
   input wire clk_i,
   input wire rst_i,
   input wire [`ADDR_W-1:0] address_i,
   input wire read_i,
   input wire write_i,
   input wire [31:0] writedata_i,
   input wire [3:0] byteenable_i,
   output reg [31:0] readdata_o,
   output reg waitrequest_o,
   input wire comp_i,
   output reg [9:0] dac_code_o,
   output reg [3:0] channel_sel_o,
   output reg busy_o,
   output reg irq_o
);

localparam ST_IDLE = 2'h0;
localparam ST_SETUP = 2'h1;
localparam ST_BITS = 2'h2;

reg [1:0] state;
reg [3:0] chan;
reg [1:0] speed;
reg eoc;
reg [9:0] sar;
reg [3:0] setup_cnt;
reg [3:0] bit_idx;
reg [1:0] edge_cnt;
reg [7:0] result_high;
reg [1:0] result_low;
reg irq_status;
reg irq_mask;
reg next_status;
reg [9:0] next_sar;
wire tick;
wire access;
wire bus_write;
wire start_req;
wire done;

assign access = (read_i | write_i) & waitrequest_o;
assign bus_write = write_i & ~waitrequest_o;
assign start_req = bus_write && address_i == `OFS_CONTROL && byteenable_i[0] && writedata_i[`CTL_START] &&
   state == ST_IDLE;
assign done = state == ST_BITS && tick && edge_cnt == `EDGES_LAST && bit_idx == 4'h0;

conv_clock_div conv_clock_div_i (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .run_i(state != ST_IDLE),
   .speed_i(speed),
   .tick_o(tick)
);

function [31:0] read_mux;
   input [`ADDR_W-1:0] addr;
   input [7:0] ctl;
   input [7:0] hi;
   input [1:0] lo;
   input st;
   input mk;
   begin
      case (addr)
         `OFS_CONTROL: read_mux = {24'h000000, ctl};
         `OFS_RESULT_HIGH: read_mux = {24'h000000, hi};
         // RULE16 low bits aligned
         `OFS_RESULT_LOW: read_mux = {30'h00000000, lo};
         `OFS_IRQ_STATUS: read_mux = {31'h00000000, st};
         `OFS_IRQ_MASK: read_mux = {31'h00000000, mk};
         default: read_mux = 32'h00000000;
      endcase
   end
endfunction

// Bus handshake: waitrequest drops for exactly one cycle per access
always @(posedge clk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      waitrequest_o <= 1'b1;
      readdata_o <= 32'h00000000;
   end
   else if (access)
   begin
      waitrequest_o <= 1'b0;
      // RULE10 busy shows as zero
      readdata_o <= read_mux(address_i, {chan, eoc, speed, state != ST_IDLE}, result_high, result_low,
         irq_status, irq_mask);
   end
   else
   begin
      waitrequest_o <= 1'b1;
   end
end

// Set wins over write-one-to-clear
always @*
begin
   next_status = irq_status;
   if (bus_write && address_i == `OFS_IRQ_STATUS && byteenable_i[0] && writedata_i[0])
   begin
      next_status = 1'b0;
   end
   if (done)
   begin
      next_status = 1'b1;
   end
end

// RULE14 decide one bit
always @*
begin
   next_sar = sar;
   if (!comp_i)
   begin
      next_sar[bit_idx] = 1'b0;
   end
   if (bit_idx != 4'h0)
   begin
      next_sar[bit_idx - 4'h1] = 1'b1;
   end
end

always @(posedge clk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      irq_status <= 1'b0;
      irq_mask <= `MASK_RESET;
      irq_o <= 1'b0;
   end
   else
   begin
      irq_status <= next_status;
      if (bus_write && address_i == `OFS_IRQ_MASK && byteenable_i[0])
      begin
         irq_mask <= writedata_i[0];
         irq_o <= next_status & writedata_i[0];
      end
      else
      begin
         irq_o <= next_status & irq_mask;
      end
   end
end

always @(posedge clk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      state <= ST_IDLE;
      chan <= `CHAN_RESET;
      speed <= 2'h0;
      eoc <= 1'b0;
      sar <= `SAR_MIDSCALE;
      setup_cnt <= 4'h0;
      bit_idx <= `TOP_BIT;
      edge_cnt <= 2'h0;
      result_high <= 8'h00;
      result_low <= 2'h0;
      dac_code_o <= `SAR_MIDSCALE;
      channel_sel_o <= 4'h0;
      busy_o <= 1'b0;
   end
   else
   begin
      // Channel and speed may change only while idle
      if (bus_write && address_i == `OFS_CONTROL && byteenable_i[0] && state == ST_IDLE)
      begin
         // RULE12 channel field
         chan <= writedata_i[`CTL_CHAN_HI:`CTL_CHAN_LO];
         channel_sel_o <= writedata_i[`CTL_CHAN_HI:`CTL_CHAN_LO];
         // RULE13 speed field
         speed <= writedata_i[`CTL_SPEED_HI:`CTL_SPEED_LO];
      end
      case (state)
         ST_IDLE:
         begin
            if (start_req)
            begin
               state <= ST_SETUP;
               eoc <= 1'b0;
               busy_o <= 1'b1;
               // RULE14 start at midscale
               sar <= `SAR_MIDSCALE;
               dac_code_o <= `SAR_MIDSCALE;
               setup_cnt <= 4'h0;
               bit_idx <= `TOP_BIT;
               edge_cnt <= 2'h0;
            end
         end
         ST_SETUP:
         begin
            // RULE2 ten set-up clocks
            if (tick)
            begin
               if (setup_cnt == `SETUP_LAST)
               begin
                  state <= ST_BITS;
               end
               else
               begin
                  setup_cnt <= setup_cnt + 4'h1;
               end
            end
         end
         ST_BITS:
         begin
            // RULE1 four edges per bit
            if (tick)
            begin
               edge_cnt <= edge_cnt + 2'h1;
               if (edge_cnt == `EDGES_LAST)
               begin
                  sar <= next_sar;
                  dac_code_o <= next_sar;
                  if (bit_idx == 4'h0)
                  begin
                     // RULE5 split result
                     // RULE15 overwrite old result
                     result_high <= next_sar[`RESULT_BITS-1:2];
                     result_low <= next_sar[1:0];
                     // RULE4 flag completion
                     eoc <= 1'b1;
                     busy_o <= 1'b0;
                     // RULE6 back to idle
                     state <= ST_IDLE;
                  end
                  else
                  begin
                     bit_idx <= bit_idx - 4'h1;
                  end
               end
            end
         end
         default:
         begin
            state <= ST_IDLE;
         end
      endcase
   end
end

endmodule // sar_adc_ctrl
`default_nettype wire

/* File: tb/sar_adc_ctrl_sva.sv */
// Port assertions for the converter control block
`timescale 1ns/10ps
`default_nettype none
module sar_adc_ctrl_sva (
   input wire clk_i,
   input wire rst_i,
   input wire [4:0] address_i,
   input wire read_i,
   input wire write_i,
   input wire [31:0] readdata_o,
   input wire waitrequest_o,
   input wire [9:0] dac_code_o,
   input wire [3:0] channel_sel_o,
   input wire busy_o,
   input wire irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("bus request not answered");
   AST_ONE: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("answer longer than one cycle");
   AST_START: assert property ($rose(busy_o) |-> $past(write_i && !waitrequest_o && address_i == 5'h00))
      else $error("conversion began without a control write");
   AST_MID: assert property ($rose(busy_o) |-> dac_code_o == 10'h200)
      else $error("code not midscale at start");
   AST_LEN: assert property ($rose(busy_o) |-> busy_o [*8] ##42 busy_o)
      else $error("conversion shorter than fifty clocks");
   AST_IDLE: assert property (!busy_o && !(write_i && !waitrequest_o) |=> !busy_o)
      else $error("conversion began by itself");
   AST_HOLD: assert property (!busy_o ##1 !busy_o |-> $stable(dac_code_o))
      else $error("code moved while idle");
   AST_CHAN: assert property (busy_o |=> $stable(channel_sel_o))
      else $error("channel moved during conversion");
   AST_LOW: assert property (!waitrequest_o && $past(read_i && address_i == 5'h08) |-> readdata_o[31:2] == 30'h0)
      else $error("unused low result bits not zero");
   AST_TOP: assert property (readdata_o[31:8] == 24'h0)
      else $error("upper read data not zero");
   cover property ($fell(busy_o));
   cover property (irq_o);
   cover property (busy_o && write_i && !waitrequest_o);
endmodule // sar_adc_ctrl_sva
bind sar_adc_ctrl sar_adc_ctrl_sva sar_adc_ctrl_sva_i (.clk_i, .rst_i, .address_i, .read_i, .write_i,
   .readdata_o, .waitrequest_o, .dac_code_o, .channel_sel_o, .busy_o, .irq_o);
`default_nettype wire

/* File: tb/comp_model.sv */
// Comparator against the resistor tree level for a fixed analog input
`timescale 1ns/10ps
`default_nettype none
module comp_model (
   input wire logic [9:0] dac_code_i,
   input wire logic [9:0] level_i,
   output logic comp_o
);
   // pins in input mode
   // The input pin is taken as already set to input mode, so the level reaches the comparator unaltered
   // High keeps the trial bit when the input is at or above the tree level
   assign comp_o = level_i >= dac_code_i;
endmodule // comp_model
`default_nettype wire

/* File: tb/sar_adc_ctrl_bench.sv */
// Register-level bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module sar_adc_ctrl_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] address_i = 5'h00;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0;
   logic [9:0] level = 10'h000;
   logic [9:0] lvs [0:3] = '{10'h3FF, 10'h000, 10'h155, 10'h2AA};
   logic [31:0] rv;
   wire [31:0] readdata_o;
   wire waitrequest_o, comp_i, busy_o, irq_o;
   wire [9:0] dac_code_o;
   wire [3:0] channel_sel_o;
   integer miscompares = 0;
   integer n_checks = 0;
   integer cnt = 0;
   integer len = 0;
   integer k, p, i;
   initial forever #4 clk_i = ~clk_i;
   // Length of the last conversion in clocks
   always @(posedge clk_i)
   begin
      cnt <= busy_o ? cnt + 1 : 0;
      if (!busy_o && cnt != 0) len <= cnt;
   end
   sar_adc_ctrl sar_adc_ctrl_i (.clk_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i,
      .byteenable_i(4'hF), .readdata_o, .waitrequest_o, .comp_i, .dac_code_o, .channel_sel_o, .busy_o, .irq_o);
   comp_model comp_model_i (.dac_code_i(dac_code_o), .level_i(level), .comp_o(comp_i));
   task end_of_test;
   begin
      $display("checks %0d errors %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   task tmo;
   begin
      miscompares = miscompares + 1;
      end_of_test;
   end
   endtask
   task chk(input [31:0] s, input [31:0] e);
   begin
      n_checks = n_checks + 1;
      if (s !== e)
      begin
         miscompares = miscompares + 1;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   end
   endtask
   // One bus access; holds the request until waitrequest is sampled low
   task bus(input w, input [4:0] a, input [7:0] d);
   begin
      @(posedge clk_i);
      write_i <= w;
      read_i <= !w;
      address_i <= a;
      writedata_i <= {24'h0, d};
      for (k = 0; k < 20 && waitrequest_o !== 1'b0; k = k + 1) @(posedge clk_i);
      if (k == 20) tmo;
      rv = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
   end
   endtask
   task conv(input [1:0] s, input [3:0] ch, input [9:0] lv);
   begin
      level <= lv;
      bus(1'b1, 5'h00, {ch, 1'b0, s, 1'b0});
      bus(1'b1, 5'h00, {ch, 1'b0, s, 1'b1});
      bus(1'b0, 5'h00, 8'h00);
      chk(rv, {24'h0, ch, 1'b0, s, 1'b1});
      bus(1'b1, 5'h00, 8'hF3);
      // Let the ignored write's edge pass before looking at the channel
      @(posedge clk_i);
      chk(channel_sel_o, ch);
      if (s == 2'h0) repeat (3) @(posedge clk_i);
      for (p = 0; p < 400 && rv[3] !== 1'b1; p = p + 1) bus(1'b0, 5'h00, 8'h00);
      if (p == 400) tmo;
      chk(rv, {24'h0, ch, 1'b1, s, 1'b0});
      chk(len, 50 * (s == 2'h3 ? 1 : 16 >> s) + 1);
      bus(1'b0, 5'h04, 8'h00);
      chk(rv, lv[9:2]);
      bus(1'b0, 5'h08, 8'h00);
      chk(rv, lv[1:0]);
   end
   endtask
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, 5'h00, 8'h00);
      chk(rv, 32'h0);
      bus(1'b0, 5'h10, 8'h00);
      chk(rv, 32'h0);
      for (i = 0; i < 4; i = i + 1) conv(i[1:0], 4'h8 - 4'h2 * i[3:0], lvs[i]);
      chk(irq_o, 32'h0);
      bus(1'b0, 5'h0C, 8'h00);
      chk(rv, 32'h1);
      bus(1'b1, 5'h10, 8'h01);
      bus(1'b0, 5'h10, 8'h00);
      chk(rv, 32'h1);
      chk(irq_o, 32'h1);
      bus(1'b1, 5'h0C, 8'h01);
      bus(1'b0, 5'h0C, 8'h00);
      chk(rv, 32'h0);
      chk(irq_o, 32'h0);
      bus(1'b1, 5'h14, 8'hFF);
      bus(1'b0, 5'h14, 8'h00);
      chk(rv, 32'h0);
      end_of_test;
   end
endmodule // sar_adc_ctrl_bench
`default_nettype wire
